// >>> rtl/caf_top.sv
// CAN transmit abort control and receive acceptance filter
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/10ps
// Summary of operation
// - Abort scheduled buffer only if not started, or attempt lost or failed.
// - Granted abort sets empty and abort-ack flags; interrupt if enabled.
// - CPU cannot clear abort requests; empty flag set clears them.
// - Per-buffer enable gates the transmitter empty interrupt.
// - Soft reset holds transmit control register at reset state.
// - Mode field: 32-bit, two 16-bit, four 8-bit filters, or closed.
// - Closed filter accepts nothing; foreground buffer never reloaded.
// - Hit field names the accepting filter, 0 to 3.
// - Hit field updates with each background to foreground copy.
// - Filter mode, code and mask registers writable only in soft reset.
// - Receive and transmit error counts readable as eight-bit registers.
// - Every message lands in background; only accepted ones reach CPU.
// - Code and mask compare bit by bit with four identifier bytes.
// - In 32-bit mode extended identifiers use four pairs, standard ones first two.
// - Mask 0 bit must match code; mask 1 bit is ignored.
// - Copy sets receive-full; no further copy while it is set.
module caf_top
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave, word addressed
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Transmit engine status per buffer
  input wire logic [2:0] tx_active_i,
  input wire logic [2:0] tx_fail_i,
  input wire logic [2:0] tx_done_i,
  // Receive engine
  input wire logic rx_valid_i,
  input wire logic [31:0] rx_id_i,
  input wire logic rx_ext_i,
  input wire logic [7:0] rx_err_count_i,
  input wire logic [7:0] tx_err_count_i,
  // Controller side outputs
  output logic [2:0] tx_empty_o,
  output logic [2:0] abort_req_o,
  output logic [2:0] abort_ack_o,
  output logic tx_empty_irq_o,
  output logic rx_full_o,
  output logic rx_copy_o,
  output logic [31:0] fg_id_o,
  output logic fg_ext_o,
  output logic [1:0] filter_hit_o,
  output logic soft_reset_o
);
  import caf_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic soft_rst;
    logic [2:0] abort_req;
    logic [2:0] irq_en;
    logic [2:0] empty;
    logic [2:0] abort_ack;
    caf_mode_e mode;
    logic [1:0] hit;
    logic [31:0] code;
    logic [31:0] mask;
    logic rx_full;
    logic [31:0] bg_id;
    logic bg_ext;
    logic bg_pend;
    logic [31:0] fg_id;
    logic fg_ext;
    logic copy;
  } caf_state_s;

  caf_state_s st_reg;
  caf_state_s st_next;

  // ****************************************
  // Filter functions
  // ****************************************
  // One byte passes when every unmasked bit equals the code
  function automatic logic caf_byte_ok(
    input logic [7:0] idb,
    input logic [7:0] code,
    input logic [7:0] mask
  );
    caf_byte_ok = ((idb ^ code) & ~mask) == 8'h00;
  endfunction : caf_byte_ok

  // Returns {accepted, hit index}; lowest filter wins
  function automatic logic [2:0] caf_filter(
    input logic [31:0] id,
    input logic ext,
    input logic [31:0] code,
    input logic [31:0] mask,
    input caf_mode_e mode
  );
    logic [3:0] f;
    f = 4'h0;
    unique case (mode)
      CAF_MODE_32:
      begin
        f[0] = caf_byte_ok(id[7:0], code[7:0], mask[7:0])
             & caf_byte_ok(id[15:8], code[15:8], mask[15:8])
             & (~ext | (caf_byte_ok(id[23:16], code[23:16], mask[23:16])
             & caf_byte_ok(id[31:24], code[31:24], mask[31:24])));
      end
      CAF_MODE_16:
      begin
        f[0] = caf_byte_ok(id[7:0], code[7:0], mask[7:0])
             & caf_byte_ok(id[15:8], code[15:8], mask[15:8]);
        f[1] = caf_byte_ok(id[7:0], code[23:16], mask[23:16])
             & caf_byte_ok(id[15:8], code[31:24], mask[31:24]);
      end
      CAF_MODE_8:
      begin
        for (int i = 0; i < 4; i++)
        begin
          f[i] = caf_byte_ok(id[7:0], code[8*i +: 8], mask[8*i +: 8]);
        end
      end
      CAF_MODE_CLOSED:
        f = 4'h0;
    endcase
    // Index of first hit; lowest filter has priority
    caf_filter = f[0] ? 3'b100 : f[1] ? 3'b101 : f[2] ? 3'b110 : f[3] ? 3'b111 : 3'b000;
  endfunction : caf_filter

  // ****************************************
  // Next state
  // ****************************************
  logic [2:0] filt;
  logic [2:0] grant;
  logic [2:0] set_empty;
  logic [2:0] clr_empty;
  logic [2:0] req_set;
  logic wr_en;
  logic copy;
  logic [7:0] wd;
  logic [7:0] rmux;

  // Filter looks at the held background message
  assign filt = caf_filter(st_reg.bg_id, st_reg.bg_ext, st_reg.code,
                           st_reg.mask, st_reg.mode);

  always_comb
  begin
    st_next = st_reg;
    wd = avs_writedata_i[7:0];
    // A write lands only at the edge where waitrequest is low
    wr_en = avs_write_i & st_reg.ack & avs_byteenable_i[0];
    // One wait state; read data captured with the ack
    st_next.ack = (avs_read_i | avs_write_i) & ~st_reg.ack;
    unique case (avs_address_i)
      IDX_CODE0, IDX_CODE1, IDX_CODE2, IDX_CODE3:
        rmux = st_reg.code[8*avs_address_i[1:0] +: 8];
      IDX_MASK0, IDX_MASK1, IDX_MASK2, IDX_MASK3:
        rmux = st_reg.mask[8*avs_address_i[1:0] +: 8];
      IDX_TX_CTRL:
        rmux = (8'(st_reg.irq_en) << TXC_IRQ_EN_LSB)
             | (8'(st_reg.abort_req) << TXC_ABORT_REQ_LSB);
      IDX_FILT_MODE:
        rmux = (8'(st_reg.hit) << FMC_HIT_LSB)
             | (8'(st_reg.mode) << FMC_MODE_LSB);
      IDX_RX_ERR:
        rmux = rx_err_count_i;
      IDX_TX_ERR:
        rmux = tx_err_count_i;
      IDX_TX_FLAG:
        rmux = (8'(st_reg.empty) << TXF_EMPTY_LSB)
             | (8'(st_reg.abort_ack) << TXF_ABORT_ACK_LSB);
      IDX_MOD_CTRL0:
        rmux = 8'(st_reg.soft_rst) << MC0_SOFT_RST_BIT;
      IDX_RX_FLAG:
        rmux = 8'(st_reg.rx_full) << RX_FLAG_FULL_BIT;
      default:
        rmux = 8'h00; // Unmapped reads return zero
    endcase
    if (avs_read_i & ~st_reg.ack)
      st_next.rdata = rmux;

    // Abort grant: not started, or this attempt lost or failed
    grant = st_reg.abort_req & ~st_reg.empty
          & (~tx_active_i | tx_fail_i);
    set_empty = tx_done_i | grant;
    clr_empty = 3'h0;
    req_set = 3'h0;
    if (wr_en && avs_address_i == IDX_TX_FLAG)
      clr_empty = wd[TXF_EMPTY_LSB +: 3];
    if (wr_en && avs_address_i == IDX_TX_CTRL)
    begin
      st_next.irq_en = wd[TXC_IRQ_EN_LSB +: 3];
      req_set = wd[TXC_ABORT_REQ_LSB +: 3]; // Writing 0 never clears
    end
    // Hardware set beats a same-cycle software clear
    st_next.empty = (st_reg.empty & ~clr_empty) | set_empty;
    // Ack clears only when the empty flag really clears
    st_next.abort_ack = (st_reg.abort_ack & ~(clr_empty & ~set_empty))
                      | grant;
    // Software keeps clear and request apart, so the request survives
    st_next.abort_req = (st_reg.abort_req | req_set)
                      & ~st_next.empty;

    // Soft reset bit itself is always writable
    if (wr_en && avs_address_i == IDX_MOD_CTRL0)
      st_next.soft_rst = wd[MC0_SOFT_RST_BIT];

    // Filter setup is locked outside soft reset
    if (wr_en && st_reg.soft_rst)
    begin
      unique case (avs_address_i)
        IDX_CODE0, IDX_CODE1, IDX_CODE2, IDX_CODE3:
          st_next.code[8*avs_address_i[1:0] +: 8] = wd;
        IDX_MASK0, IDX_MASK1, IDX_MASK2, IDX_MASK3:
          st_next.mask[8*avs_address_i[1:0] +: 8] = wd;
        IDX_FILT_MODE:
          st_next.mode = caf_mode_e'(wd[FMC_MODE_LSB +: 2]);
        default: ;
      endcase
    end

    // Exchange only into a free foreground buffer
    copy = st_reg.bg_pend & ~st_reg.rx_full & filt[2]
         & ~st_reg.soft_rst;
    st_next.copy = copy;
    if (copy)
    begin
      st_next.fg_id = st_reg.bg_id;
      st_next.fg_ext = st_reg.bg_ext;
      st_next.hit = filt[1:0];
    end
    // Rejected message is dropped; accepted one waits for room
    if (st_reg.bg_pend && (copy || !filt[2]))
      st_next.bg_pend = 1'b0;
    // Every reception overwrites the background buffer
    if (rx_valid_i)
    begin
      st_next.bg_id = rx_id_i;
      st_next.bg_ext = rx_ext_i;
      st_next.bg_pend = 1'b1;
    end
    // Full flag: copy beats a same-cycle clear
    if (wr_en && avs_address_i == IDX_RX_FLAG && wd[RX_FLAG_FULL_BIT])
      st_next.rx_full = 1'b0;
    if (copy)
      st_next.rx_full = 1'b1;

    // Soft reset holds control and flag registers
    if (st_reg.soft_rst)
    begin
      st_next.abort_req = 3'h0;
      st_next.irq_en = 3'h0;
      st_next.empty = EMPTY_RST;
      st_next.abort_ack = 3'h0;
      st_next.rx_full = 1'b0;
    end

    // Hard reset, filter contents survive
    if (sys_rst_i)
    begin
      st_next = '0;
      st_next.soft_rst = SOFT_RST_RST;
      st_next.empty = EMPTY_RST;
      st_next.code = st_reg.code;
      st_next.mask = st_reg.mask;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    st_reg <= st_next;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_readdata_o = {24'h000000, st_reg.rdata};
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_reg.ack;
  assign tx_empty_o = st_reg.empty;
  assign abort_req_o = st_reg.abort_req;
  assign abort_ack_o = st_reg.abort_ack;
  // Pending while any enabled buffer is empty
  assign tx_empty_irq_o = |(st_reg.empty & st_reg.irq_en);
  assign rx_full_o = st_reg.rx_full;
  assign rx_copy_o = st_reg.copy;
  assign fg_id_o = st_reg.fg_id;
  assign fg_ext_o = st_reg.fg_ext;
  assign filter_hit_o = st_reg.hit;
  assign soft_reset_o = st_reg.soft_rst;

  // ****************************************
  // Assertions
  // ****************************************
  logic [2:0] blk;
  assign blk = st_reg.abort_req & ~st_reg.empty & tx_active_i & ~tx_fail_i;

  property p_abort_grant;
    @(posedge clk_i) disable iff (sys_rst_i)
    (grant != 3'h0 && !st_reg.soft_rst)
      |=> ((st_reg.empty & $past(grant)) == $past(grant))
          && ((st_reg.abort_ack & $past(grant)) == $past(grant));
  endproperty
  a_abort_grant: assert property (p_abort_grant)
    else $error("granted abort did not set empty and ack");

  property p_abort_blocked;
    @(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> ((st_reg.abort_ack & ~$past(st_reg.abort_ack) & $past(blk)) == 3'h0);
  endproperty
  a_abort_blocked: assert property (p_abort_blocked)
    else $error("abort granted during a running attempt");

  property p_req_cleared;
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_reg.abort_req & st_reg.empty) == 3'h0;
  endproperty
  a_req_cleared: assert property (p_req_cleared)
    else $error("abort request left set on empty buffer");

  property p_irq_gate;
    @(posedge clk_i) disable iff (sys_rst_i)
    ((set_empty & ~st_reg.empty & st_reg.irq_en) != 3'h0 && !st_reg.soft_rst
      && !(wr_en && avs_address_i == IDX_TX_CTRL)) |=> tx_empty_irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("enabled empty event raised no interrupt");

  property p_soft_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
    st_reg.soft_rst |=> st_reg.abort_req == 3'h0 && st_reg.irq_en == 3'h0;
  endproperty
  a_soft_hold: assert property (p_soft_hold)
    else $error("transmit control not held in soft reset");

  property p_closed;
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_reg.mode == CAF_MODE_CLOSED)[*2]
      |-> !st_reg.copy && $stable(st_reg.hit);
  endproperty
  a_closed: assert property (p_closed)
    else $error("closed filter reloaded foreground");

  property p_lock;
    @(posedge clk_i) disable iff (sys_rst_i)
    (wr_en && !st_reg.soft_rst)
      |=> $stable(st_reg.code) && $stable(st_reg.mask)
          && $stable(st_reg.mode);
  endproperty
  a_lock: assert property (p_lock)
    else $error("filter setup changed outside soft reset");

  property p_copy_full;
    @(posedge clk_i) disable iff (sys_rst_i)
    st_reg.copy |-> st_reg.rx_full && !$past(st_reg.rx_full);
  endproperty
  a_copy_full: assert property (p_copy_full)
    else $error("copy into full foreground buffer");

  property p_hit_copy;
    @(posedge clk_i) disable iff (sys_rst_i)
    st_reg.copy |-> st_reg.hit == $past(filt[1:0])
                    && st_reg.fg_id == $past(st_reg.bg_id);
  endproperty
  a_hit_copy: assert property (p_hit_copy)
    else $error("hit field not updated with copy");

  property p_err_read;
    @(posedge clk_i) disable iff (sys_rst_i)
    (avs_read_i && !st_reg.ack && avs_address_i == IDX_RX_ERR)
      |=> avs_readdata_o == {24'h000000, $past(rx_err_count_i)};
  endproperty
  a_err_read: assert property (p_err_read)
    else $error("receive error count read wrong");

  property p_bg_load;
    @(posedge clk_i) disable iff (sys_rst_i)
    rx_valid_i |=> st_reg.bg_pend && st_reg.bg_id == $past(rx_id_i);
  endproperty
  a_bg_load: assert property (p_bg_load)
    else $error("reception not stored in background");

endmodule : caf_top

// >>> common/caf_pkg.sv
// Constants and types for the CAN abort and acceptance filter block
package caf_pkg;

  // ****************************************
  // Register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [11:0] IDX_CODE0 = 12'h510;
  localparam logic [11:0] IDX_CODE1 = 12'h511;
  localparam logic [11:0] IDX_CODE2 = 12'h512;
  localparam logic [11:0] IDX_CODE3 = 12'h513;
  localparam logic [11:0] IDX_MASK0 = 12'h514;
  localparam logic [11:0] IDX_MASK1 = 12'h515;
  localparam logic [11:0] IDX_MASK2 = 12'h516;
  localparam logic [11:0] IDX_MASK3 = 12'h517;
  localparam logic [11:0] IDX_TX_CTRL = 12'h518;
  localparam logic [11:0] IDX_FILT_MODE = 12'h519;
  localparam logic [11:0] IDX_RX_ERR = 12'h51a;
  localparam logic [11:0] IDX_TX_ERR = 12'h51b;
  localparam logic [11:0] IDX_TX_FLAG = 12'h51c;
  localparam logic [11:0] IDX_MOD_CTRL0 = 12'h51d;
  localparam logic [11:0] IDX_RX_FLAG = 12'h51e;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TXC_IRQ_EN_LSB = 0;
  localparam int TXC_ABORT_REQ_LSB = 4;
  localparam int TXF_EMPTY_LSB = 0;
  localparam int TXF_ABORT_ACK_LSB = 4;
  localparam int FMC_HIT_LSB = 0;
  localparam int FMC_MODE_LSB = 4;
  localparam int MC0_SOFT_RST_BIT = 0;
  localparam int RX_FLAG_FULL_BIT = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0] EMPTY_RST = 3'h7;
  localparam logic SOFT_RST_RST = 1'b1;

  // Filter organisation, encoded as in the mode field
  typedef enum logic [1:0] {
    CAF_MODE_32,
    CAF_MODE_16,
    CAF_MODE_8,
    CAF_MODE_CLOSED
  } caf_mode_e;

endpackage : caf_pkg

// >>> testbench/caf_can_model.sv
// Stand-in for the CAN engine: transmit status per buffer and received identifiers
`timescale 1ns/10ps
module caf_can_model
(
  // Clock
  input wire logic clk_i,
  // Transmit status towards the block
  output logic [2:0] tx_active_o,
  output logic [2:0] tx_fail_o,
  output logic [2:0] tx_done_o,
  // Receive side towards the block
  output logic rx_valid_o,
  output logic [31:0] rx_id_o,
  output logic rx_ext_o,
  output logic [7:0] rx_err_count_o,
  output logic [7:0] tx_err_count_o
);
  // Idle engine at time zero
  initial
  begin
    tx_active_o = 3'h0;
    tx_fail_o = 3'h0;
    tx_done_o = 3'h0;
    rx_valid_o = 1'b0;
    rx_id_o = 32'h0;
    rx_ext_o = 1'b0;
    rx_err_count_o = 8'h0;
    tx_err_count_o = 8'h0;
  end
  // Start or end a transmission attempt of one buffer
  task automatic set_active(input int b, input logic v);
    @(posedge clk_i);
    tx_active_o[b] <= v;
  endtask : set_active
  // One-cycle pulse: failed attempt, or successful send when done_kind is set
  task automatic pulse(input logic done_kind, input int b);
    @(posedge clk_i);
    if (done_kind)
      tx_done_o[b] <= 1'b1;
    else
      tx_fail_o[b] <= 1'b1;
    @(posedge clk_i);
    tx_done_o <= 3'h0;
    tx_fail_o <= 3'h0;
  endtask : pulse
  // One received frame; id lines show junk afterwards so stale values are never relied on
  task automatic send(input logic [31:0] id, input logic ext);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_id_o <= id;
    rx_ext_o <= ext;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_id_o <= ~id;
    rx_ext_o <= ~ext;
  endtask : send
  // Error counter values as the engine would hold them
  task automatic set_err(input logic [7:0] r, input logic [7:0] t);
    @(posedge clk_i);
    rx_err_count_o <= r;
    tx_err_count_o <= t;
  endtask : set_err
endmodule : caf_can_model

// >>> testbench/caf_top_tb.sv
// Self-checking bench for the CAN abort and acceptance filter block
`timescale 1ns/10ps
module caf_top_tb;
  import caf_pkg::*;
  typedef struct {
    caf_mode_e mode;
    logic [31:0] code;
    logic [31:0] mask;
    logic [31:0] id;
    logic ext;
    logic acc;
    logic [1:0] hit;
  } caf_row_s;
  logic clk_i;
  logic sys_rst_i;
  logic [11:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [2:0] tx_active, tx_fail, tx_done, tx_empty_o, abort_req_o, abort_ack_o;
  logic rx_valid, rx_ext, tx_empty_irq_o, rx_full_o, rx_copy_o, fg_ext_o, soft_reset_o;
  logic [31:0] rx_id, fg_id_o;
  logic [7:0] rx_err, tx_err;
  logic [1:0] filter_hit_o, hit0;
  int n_mismatch = 0;
  int check_count = 0;
  // Filter cases: mode, code, mask, id, extended, accepted, hit
  caf_row_s rows[9] = '{
    '{CAF_MODE_32, 32'h12345678, 32'h0, 32'h12345678, 1'b1, 1'b1, 2'h0},
    '{CAF_MODE_32, 32'h12345678, 32'h0, 32'h12345679, 1'b1, 1'b0, 2'h0},
    '{CAF_MODE_32, 32'h12345678, 32'h000000ff, 32'h123456aa, 1'b1, 1'b1, 2'h0},
    '{CAF_MODE_32, 32'h12345678, 32'h00000700, 32'haabb5178, 1'b0, 1'b1, 2'h0},
    '{CAF_MODE_32, 32'h12345678, 32'h00000700, 32'haabb5178, 1'b1, 1'b0, 2'h0},
    '{CAF_MODE_16, 32'hcdab1234, 32'h0, 32'h0000cdab, 1'b1, 1'b1, 2'h1},
    '{CAF_MODE_8, 32'h44332211, 32'h0, 32'h00000033, 1'b1, 1'b1, 2'h2},
    '{CAF_MODE_8, 32'h44332211, 32'h0, 32'h00000044, 1'b0, 1'b1, 2'h3},
    '{CAF_MODE_CLOSED, 32'h44332211, 32'hffffffff, 32'h44332211, 1'b1, 1'b0, 2'h0}
  };

  // Design under test and engine stand-in
  caf_top i_caf_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(4'h1),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .tx_active_i(tx_active), .tx_fail_i(tx_fail),
    .tx_done_i(tx_done), .rx_valid_i(rx_valid), .rx_id_i(rx_id), .rx_ext_i(rx_ext),
    .rx_err_count_i(rx_err), .tx_err_count_i(tx_err), .tx_empty_o(tx_empty_o),
    .abort_req_o(abort_req_o), .abort_ack_o(abort_ack_o), .tx_empty_irq_o(tx_empty_irq_o),
    .rx_full_o(rx_full_o), .rx_copy_o(rx_copy_o), .fg_id_o(fg_id_o), .fg_ext_o(fg_ext_o),
    .filter_hit_o(filter_hit_o), .soft_reset_o(soft_reset_o));
  caf_can_model i_caf_can_model (.clk_i(clk_i), .tx_active_o(tx_active),
    .tx_fail_o(tx_fail), .tx_done_o(tx_done), .rx_valid_o(rx_valid), .rx_id_o(rx_id),
    .rx_ext_o(rx_ext), .rx_err_count_o(rx_err), .tx_err_count_o(tx_err));

  // Clock at 100 MHz
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  // Compare one value
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  // One bus access, held until waitrequest is seen low; bounded wait
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0)
        break;
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n == 20)
    begin
      n_mismatch++;
      close_out();
    end
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  // Compare a register read
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk_val(q, exp);
  endtask : chk_rd
  // Let updates land before looking at outputs
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  // Main sequence
  initial
  begin
    sys_rst_i = 1'b1;
    avs_address_i = 12'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk_rd(IDX_TX_FLAG, 32'h07);
    chk_rd(IDX_MOD_CTRL0, 32'h01);
    chk_rd(IDX_TX_CTRL, 32'h00);
    chk_rd(IDX_FILT_MODE, 32'h00);
    chk_rd(12'h5ff, 32'h00);
    i_caf_can_model.set_err(8'h5c, 8'ha3);
    chk_rd(IDX_RX_ERR, 32'h5c);
    chk_rd(IDX_TX_ERR, 32'ha3);
    $display("test reset and counters done");
    // Filter table: configure in soft reset, run, offer one frame
    foreach (rows[k])
    begin
      wr(IDX_MOD_CTRL0, 8'h01);
      wr(IDX_FILT_MODE, {2'b00, rows[k].mode, 4'h0});
      for (int j = 0; j < 4; j++)
      begin
        wr(IDX_CODE0 + 12'(j), rows[k].code[8*j +: 8]);
        wr(IDX_MASK0 + 12'(j), rows[k].mask[8*j +: 8]);
      end
      wr(IDX_MOD_CTRL0, 8'h00);
      wr(IDX_RX_FLAG, 8'h01);
      settle(0);
      hit0 = filter_hit_o;
      i_caf_can_model.send(rows[k].id, rows[k].ext);
      settle(1);
      chk_val(32'(rx_copy_o), 32'(rows[k].acc));
      settle(1);
      chk_val(32'(rx_copy_o), 32'h0);
      chk_val(32'(rx_full_o), 32'(rows[k].acc));
      chk_val(32'(filter_hit_o), 32'(rows[k].acc ? rows[k].hit : hit0));
      if (rows[k].acc)
      begin
        chk_val(fg_id_o, rows[k].id);
        chk_val(32'(fg_ext_o), 32'(rows[k].ext));
        // A second frame must wait while the foreground is still full
        i_caf_can_model.send(rows[k].id, ~rows[k].ext);
        settle(3);
        chk_val(32'({rx_full_o, fg_ext_o}), 32'({1'b1, rows[k].ext}));
        wr(IDX_RX_FLAG, 8'h01);
      end
      $display("test filter row %0d done", k);
    end
    // Abort refused while sending, granted when the attempt fails
    wr(IDX_TX_CTRL, 8'h01);
    settle(0);
    chk_val(32'(tx_empty_irq_o), 32'h1);
    wr(IDX_TX_FLAG, 8'h01);
    i_caf_can_model.set_active(0, 1'b1);
    wr(IDX_TX_CTRL, 8'h11);
    wr(IDX_TX_CTRL, 8'h01);
    settle(1);
    chk_val(32'({tx_empty_irq_o, abort_req_o, tx_empty_o}), 32'h0e);
    i_caf_can_model.pulse(1'b0, 0);
    settle(1);
    chk_val(32'({tx_empty_irq_o, abort_ack_o, abort_req_o, tx_empty_o}), 32'h247);
    // Abort of a buffer not yet started, interrupt disabled
    i_caf_can_model.set_active(0, 1'b0);
    wr(IDX_TX_FLAG, 8'h02);
    wr(IDX_TX_CTRL, 8'h20);
    settle(2);
    chk_val(32'({tx_empty_irq_o, abort_ack_o, abort_req_o, tx_empty_o}), 32'h0c7);
    // Successful send leaves the acknowledge clear
    wr(IDX_TX_FLAG, 8'h04);
    i_caf_can_model.pulse(1'b1, 2);
    settle(1);
    chk_rd(IDX_TX_FLAG, 32'h37);
    chk_rd(IDX_TX_CTRL, 32'h00);
    $display("test transmit abort done");
    // Soft reset holds the transmit control register
    wr(IDX_TX_CTRL, 8'h04);
    settle(0);
    chk_val(32'(tx_empty_irq_o), 32'h1);
    wr(IDX_MOD_CTRL0, 8'h01);
    wr(IDX_TX_CTRL, 8'h07);
    chk_rd(IDX_TX_CTRL, 32'h00);
    settle(0);
    chk_val(32'(tx_empty_irq_o), 32'h0);
    // Code register locked while running
    wr(IDX_MOD_CTRL0, 8'h00);
    wr(IDX_CODE0, 8'ha5);
    chk_rd(IDX_CODE0, 32'h11);
    $display("test soft reset and lock done");
    // Second hard reset keeps filter contents
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    settle(0);
    chk_val(32'({soft_reset_o, abort_req_o, tx_empty_o}), 32'h47);
    chk_rd(IDX_CODE0, 32'h11);
    chk_rd(IDX_MASK3, 32'hff);
    $display("test second reset done");
    close_out();
  end
endmodule : caf_top_tb
